// *** pcr_pkg.sv ***
// Contract
// - operator start raises an interrupt request and loads status from reader lines
// - status read returns status word including the ready-to-read flag
// - control write with pick bit picks one card and clears start interrupt
// - each column strobe latches data into the buffer and raises an interrupt
// - status shows data present while the buffered column is untaken
// - data read returns the buffer and clears the column interrupt
// - strobe, interrupt, status and data reads repeat for all 80 columns
// - after the last column the status word shows end of card
// - no card is fed unless the program issues another pick
// - malfunction, hopper empty, stacker full are reported; halt at card end
// - after a halt, resume only after fault gone, clear then start switch
// - keep pace with 1000 cards per minute, 830 on the slower timing
package pcr_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_STATUS     = 8'h00;
	localparam logic [7:0] ADDR_CONTROL    = 8'h04;
	localparam logic [7:0] ADDR_DATA       = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
	// ==========================================================
	// status word bits
	localparam int ST_READY        = 0;
	localparam int ST_DATA_PRESENT = 1;
	localparam int ST_END_OF_CARD  = 2;
	localparam int ST_MALFUNCTION  = 3;
	localparam int ST_HOPPER_EMPTY = 4;
	localparam int ST_STACKER_FULL = 5;
	localparam int ST_HALTED       = 6;
	localparam int ST_OVERRUN      = 7;
	localparam int ST_BUSY         = 8;
	// control word bits
	localparam int CTL_PICK = 0;
	// event bits, shared by irq status, clear and enable
	localparam int EV_START  = 0;
	localparam int EV_COLUMN = 1;
	localparam int EV_EOC    = 2;
	localparam int EV_FAULT  = 3;
	localparam int EV_W      = 4;
	localparam logic [EV_W-1:0] IRQ_ENABLE_RESET = 4'h0;
	// ==========================================================
	// card geometry and pacing
	localparam int               COL_DATA_W = 12;
	localparam int               COL_CNT_W  = 7;
	localparam logic [COL_CNT_W-1:0] COLUMNS_PER_CARD = 7'h50; // 80 columns
	localparam int CARDS_PER_MIN_60HZ = 1000;
	localparam int CARDS_PER_MIN_50HZ = 830;
	localparam int CLK_HZ             = 10_000_000;
	// fastest column spacing in cycles: one column per strobe, rounded down
	localparam int COL_PERIOD_CYC =
		(CLK_HZ * 60) / (CARDS_PER_MIN_60HZ * 80);
	// reader control states
	typedef enum logic [1:0] {PCR_IDLE, PCR_READY, PCR_READING, PCR_HALTED} pcr_state_t;
endpackage : pcr_pkg

// *** pcr_card_reader.sv ***
`timescale 1ns/10ps
`default_nettype none
module pcr_card_reader (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              ce,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [7:0]                        paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              rdr_start_sw,
	input  wire logic                              rdr_clear_sw,
	input  wire logic                              rdr_col_strobe,
	input  wire logic [pcr_pkg::COL_DATA_W-1:0]    rdr_col_data,
	input  wire logic                              rdr_malfunction,
	input  wire logic                              rdr_hopper_empty,
	input  wire logic                              rdr_stacker_full,
	output logic                                   rdr_pick,
	output logic                                   irq
);
	// ==========================================================
	// bus decode
	pcr_pkg::pcr_state_t                  state_q;
	logic [pcr_pkg::COL_DATA_W-1:0]       buf_q;
	logic                                 data_present_q;
	logic                                 overrun_q;
	logic                                 eoc_q;
	logic                                 fault_q;
	logic                                 clear_armed_q;
	logic [pcr_pkg::COL_CNT_W-1:0]        col_cnt_q;
	logic [pcr_pkg::EV_W-1:0]             ev_q;
	logic [pcr_pkg::EV_W-1:0]             ev_en_q;
	logic [31:0]                          status_w;
	logic                                 acc;
	logic                                 wr;
	logic                                 rd;
	logic                                 mapped;
	logic                                 pick_cmd;
	logic                                 data_take;
	logic                                 fault_in;
	logic                                 col_take;
	logic                                 last_col;

	// the access completes on the edge where our registered pready is seen high
	assign acc       = ce & psel & penable & pready;
	assign wr        = acc & pwrite & ~pslverr;
	assign rd        = acc & ~pwrite & ~pslverr;
	assign mapped    = (paddr == pcr_pkg::ADDR_STATUS) | (paddr == pcr_pkg::ADDR_CONTROL)
		| (paddr == pcr_pkg::ADDR_DATA) | (paddr == pcr_pkg::ADDR_IRQ_STATUS)
		| (paddr == pcr_pkg::ADDR_IRQ_CLEAR) | (paddr == pcr_pkg::ADDR_IRQ_ENABLE);
	assign pick_cmd  = wr & (paddr == pcr_pkg::ADDR_CONTROL) & pwdata[pcr_pkg::CTL_PICK];
	assign data_take = rd & (paddr == pcr_pkg::ADDR_DATA);
	assign fault_in  = rdr_malfunction | rdr_hopper_empty | rdr_stacker_full;
	// a strobe is only honoured while a card is moving through the read station
	assign col_take  = ce & rdr_col_strobe & (state_q == pcr_pkg::PCR_READING);
	assign last_col  = col_take & (col_cnt_q == pcr_pkg::COLUMNS_PER_CARD - 7'h01);

	// ==========================================================
	// status word, assembled live from reader lines and control state
	always_comb begin
		status_w = 32'h0;
		status_w[pcr_pkg::ST_READY]        = (state_q == pcr_pkg::PCR_READY);
		status_w[pcr_pkg::ST_DATA_PRESENT] = data_present_q;
		status_w[pcr_pkg::ST_END_OF_CARD]  = eoc_q;
		status_w[pcr_pkg::ST_MALFUNCTION]  = rdr_malfunction;
		status_w[pcr_pkg::ST_HOPPER_EMPTY] = rdr_hopper_empty;
		status_w[pcr_pkg::ST_STACKER_FULL] = rdr_stacker_full;
		status_w[pcr_pkg::ST_HALTED]       = (state_q == pcr_pkg::PCR_HALTED);
		status_w[pcr_pkg::ST_OVERRUN]      = overrun_q;
		status_w[pcr_pkg::ST_BUSY]         = (state_q == pcr_pkg::PCR_READING);
	end

	// ==========================================================
	// apb slave: one wait state, registered answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & ~pwrite) begin
				unique case (paddr)
					pcr_pkg::ADDR_STATUS:     prdata <= status_w;
					pcr_pkg::ADDR_DATA:       prdata <= {20'h0, buf_q};
					pcr_pkg::ADDR_IRQ_STATUS: prdata <= {28'h0, ev_q};
					pcr_pkg::ADDR_IRQ_ENABLE: prdata <= {28'h0, ev_en_q};
					default:                  prdata <= 32'h0; // write-only or unmapped
				endcase
			end
		end
	end

	// ==========================================================
	// reader sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pcr_pkg::PCR_IDLE;
		end else if (ce) begin
			unique case (state_q)
				pcr_pkg::PCR_IDLE:
					if (rdr_start_sw & ~fault_in) state_q <= pcr_pkg::PCR_READY;
				pcr_pkg::PCR_READY:
					if (fault_in) state_q <= pcr_pkg::PCR_HALTED;
					else if (pick_cmd) state_q <= pcr_pkg::PCR_READING;
				pcr_pkg::PCR_READING:
					// a fault lets the current card finish, then stops the reader
					if (last_col) state_q <= (fault_q | fault_in)
						? pcr_pkg::PCR_HALTED : pcr_pkg::PCR_READY;
				pcr_pkg::PCR_HALTED:
					if (clear_armed_q & rdr_start_sw & ~fault_in)
						state_q <= pcr_pkg::PCR_READY;
			endcase
		end
	end

	// pick pulse: one cycle, only on command, never on the control's own
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rdr_pick <= 1'b0;
		else if (ce) rdr_pick <= pick_cmd & (state_q == pcr_pkg::PCR_READY) & ~fault_in;
	end

	// fault latch and clear-switch arming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q       <= 1'b0;
			clear_armed_q <= 1'b0;
		end else if (ce) begin
			if (fault_in) fault_q <= 1'b1;
			else if (state_q != pcr_pkg::PCR_READING) fault_q <= 1'b0;
			// clear only arms once the fault has gone; a new fault disarms it
			if (fault_in | (state_q != pcr_pkg::PCR_HALTED)) clear_armed_q <= 1'b0;
			else if (rdr_clear_sw) clear_armed_q <= 1'b1;
		end
	end

	// ==========================================================
	// column buffer and counting; a single-cycle latch keeps pace only while each column is taken before the next strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_q          <= '0;
			data_present_q <= 1'b0;
			overrun_q      <= 1'b0;
			col_cnt_q      <= '0;
			eoc_q          <= 1'b0;
		end else if (ce) begin
			if (col_take) buf_q <= rdr_col_data;
			// new column wins over a take in the same cycle
			if (col_take) data_present_q <= 1'b1;
			else if (data_take) data_present_q <= 1'b0;
			if (col_take & data_present_q & ~data_take) overrun_q <= 1'b1;
			else if (pick_cmd) overrun_q <= 1'b0;
			if (pick_cmd & (state_q == pcr_pkg::PCR_READY)) col_cnt_q <= '0;
			else if (col_take) col_cnt_q <= col_cnt_q + 7'h01;
			if (last_col) eoc_q <= 1'b1;
			else if (pick_cmd) eoc_q <= 1'b0;
		end
	end

	// ==========================================================
	// interrupt events: sticky, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_q    <= '0;
			ev_en_q <= pcr_pkg::IRQ_ENABLE_RESET;
		end else if (ce) begin
			if (wr & (paddr == pcr_pkg::ADDR_IRQ_ENABLE)) ev_en_q <= pwdata[pcr_pkg::EV_W-1:0];
			ev_q <= (ev_q
				& ~((wr & (paddr == pcr_pkg::ADDR_IRQ_CLEAR)) ? pwdata[pcr_pkg::EV_W-1:0] : 4'h0)
				& ~(pick_cmd ? 4'h1 : 4'h0)
				& ~(data_take ? 4'h2 : 4'h0))
				| {fault_in & ~fault_q, last_col,
				   col_take,
				   (state_q != pcr_pkg::PCR_READY) & rdr_start_sw & ~fault_in
				   & ((state_q == pcr_pkg::PCR_IDLE) | clear_armed_q)};
		end
	end

	// level interrupt from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq <= 1'b0;
		else if (ce) irq <= |(ev_q & ev_en_q);
	end

	// ==========================================================
	// checks
	a_pick_only_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		rdr_pick |-> $past(pick_cmd)) else $error("pick without command");
	a_pick_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(ce & pick_cmd & state_q == pcr_pkg::PCR_READY & ~fault_in) |=> rdr_pick)
		else $error("pick command lost");
	a_col_latch: assert property (@(posedge pclk) disable iff (!presetn)
		col_take |=> (buf_q == $past(rdr_col_data)) && data_present_q && ev_q[1])
		else $error("column not latched");
	a_take_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(data_take & ~col_take) |=> ~data_present_q && ~ev_q[1])
		else $error("data read did not clear");
	a_eoc_count: assert property (@(posedge pclk) disable iff (!presetn)
		last_col |=> eoc_q && col_cnt_q == pcr_pkg::COLUMNS_PER_CARD)
		else $error("end of card not shown after 80 columns");
	a_halt_fault: assert property (@(posedge pclk) disable iff (!presetn)
		(last_col & (fault_q | fault_in)) |=> state_q == pcr_pkg::PCR_HALTED)
		else $error("no halt at card end on fault");
	a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == pcr_pkg::PCR_HALTED & ~clear_armed_q) |=> state_q == pcr_pkg::PCR_HALTED)
		else $error("resumed without clear");
	a_start_irq: assert property (@(posedge pclk) disable iff (!presetn)
		(ce & state_q == pcr_pkg::PCR_IDLE & rdr_start_sw & ~fault_in)
		|=> ev_q[0] && state_q == pcr_pkg::PCR_READY) else $error("start not flagged");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		(ce & |(ev_q & ev_en_q)) |=> irq) else $error("irq not raised");
	c_full_card: cover property (@(posedge pclk) disable iff (!presetn) last_col);
	c_halt: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == pcr_pkg::PCR_HALTED ##[1:1000] state_q == pcr_pkg::PCR_READY);
	c_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(overrun_q));
	c_column_taken: cover property (@(posedge pclk) disable iff (!presetn) data_take);

	// ==========================================================
	// further checks on the bus answer and the card sequence
	// the answer must come exactly one cycle into the access phase
	a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(ce & psel & penable & ~pready) |=> pready)
		else $error("bus answer missing");
	// a clean card end returns to ready and feeds no card in the next cycle
	a_eoc_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(last_col & ~fault_q & ~fault_in) |=> state_q == pcr_pkg::PCR_READY && ~rdr_pick)
		else $error("card end did not return to ready");
	// the column counter may never run past one card
	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		col_cnt_q <= pcr_pkg::COLUMNS_PER_CARD)
		else $error("column count beyond card");
	// a column landing on an untaken one must be flagged, the older is lost
	a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(col_take & data_present_q & ~data_take) |=> overrun_q)
		else $error("overrun not flagged");
endmodule : pcr_card_reader
`default_nettype wire

// *** pcr_reader_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// reader mechanism: one card of columns per pick
module pcr_reader_model #(
	parameter int GAP_CYC = 40
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           rdr_pick,
	output var  logic                           rdr_col_strobe,
	output var  logic [pcr_pkg::COL_DATA_W-1:0] rdr_col_data
);
	int left_q;
	int gap_q;
	// the card only moves after a pick; gap leaves room for two reads per column
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q         <= 0;
			gap_q          <= 0;
			rdr_col_strobe <= 1'b0;
			rdr_col_data   <= 12'h000;
		end else begin
			if (rdr_pick && left_q == 0) begin
				left_q         <= 80;
				gap_q          <= GAP_CYC;
				rdr_col_strobe <= 1'b0;
				rdr_col_data   <= ~rdr_col_data; // not valid between strobes
			end else if (left_q > 0 && gap_q == 0) begin
				rdr_col_strobe <= 1'b1;
				rdr_col_data   <= 12'h5a0 ^ 12'(80 - left_q);
				left_q         <= left_q - 1;
				gap_q          <= GAP_CYC;
			end else begin
				rdr_col_strobe <= 1'b0;
				rdr_col_data   <= ~rdr_col_data; // not valid between strobes
				if (left_q > 0) gap_q <= gap_q - 1;
			end
		end
	end
endmodule : pcr_reader_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, rdr_pick, irq, strobe, err;
	logic sw_start = 1'b0, sw_clear = 1'b0, hop = 1'b0, mal = 1'b0, stk = 1'b0;
	logic [11:0] cdata;
	int bad_count = 0, checks_done = 0, strobes = 0;
	always #50 pclk = ~pclk;
	pcr_card_reader dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rdr_start_sw(sw_start),
		.rdr_clear_sw(sw_clear), .rdr_col_strobe(strobe), .rdr_col_data(cdata),
		.rdr_malfunction(mal), .rdr_hopper_empty(hop), .rdr_stacker_full(stk),
		.rdr_pick(rdr_pick), .irq(irq));
	pcr_reader_model rdr_u (.pclk(pclk), .presetn(presetn), .rdr_pick(rdr_pick),
		.rdr_col_strobe(strobe), .rdr_col_data(cdata));
	// strobe tally shows whether the reader was fed without a pick
	always @(posedge pclk) if (strobe === 1'b1) strobes++;
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		rv = prdata;
		err = pslverr;
		if (n >= 50) check("pready", 32'h1, 32'h0);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check("reg", e, rv & m);
	endtask : rdm
	task automatic irq_is(input logic e);
		repeat (2) @(posedge pclk);
		check("irq", {31'h0, e}, {31'h0, irq});
	endtask : irq_is
	// operator switch held for a few cycles; clr picks the clear switch
	task automatic press(input bit clr);
		@(posedge pclk);
		if (clr) sw_clear <= 1'b1;
		else sw_start <= 1'b1;
		repeat (3) @(posedge pclk);
		if (clr) sw_clear <= 1'b0;
		else sw_start <= 1'b0;
	endtask : press
	task automatic read_card(input bit fault);
		int n;
		for (int i = 0; i < 80; i++) begin
			n = 0;
			do begin apb(1'b0, pcr_pkg::ADDR_STATUS, 0); n++; end
			while (rv[pcr_pkg::ST_DATA_PRESENT] !== 1'b1 && n < 100);
			check("present", 32'h2, rv & 32'h2);
			if (fault) check("hopper", 32'h10, rv & 32'h10);
			if (i == 0) rdm(pcr_pkg::ADDR_IRQ_STATUS, 32'h2, 32'h2);
			rdm(pcr_pkg::ADDR_DATA, 32'hfff, 32'(12'h5a0 ^ 12'(i)));
			if (i == 0) rdm(pcr_pkg::ADDR_IRQ_STATUS, 32'h2, 32'h0);
			if (i == 10 && !fault) rdm(pcr_pkg::ADDR_STATUS, 32'h2, 32'h0);
		end
		repeat (60) @(posedge pclk);
		rdm(pcr_pkg::ADDR_STATUS, 32'h4, 32'h4);
	endtask : read_card
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	initial begin #3_000_000; bad_count++; results(); end
	// ==========================================
	// main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdm(pcr_pkg::ADDR_IRQ_ENABLE, 32'hf, 32'h0);
		rdm(pcr_pkg::ADDR_STATUS, 32'h1ff, 32'h0);
		apb(1'b0, 8'h40, 0);
		check("slverr", 32'h1, {31'h0, err});
		apb(1'b1, pcr_pkg::ADDR_IRQ_ENABLE, 32'hf);
		apb(1'b1, pcr_pkg::ADDR_CONTROL, 32'h1);
		rdm(pcr_pkg::ADDR_STATUS, 32'h1, 32'h0);
		press(1'b0);
		rdm(pcr_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
		rdm(pcr_pkg::ADDR_STATUS, 32'h1, 32'h1);
		irq_is(1'b1);
		apb(1'b1, pcr_pkg::ADDR_CONTROL, 32'h1);
		rdm(pcr_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h0);
		read_card(1'b0);
		check("strobes", 32'd80, 32'(strobes));
		apb(1'b1, pcr_pkg::ADDR_IRQ_ENABLE, 32'h0);
		irq_is(1'b0);
		apb(1'b1, pcr_pkg::ADDR_IRQ_ENABLE, 32'hf);
		irq_is(1'b1);
		apb(1'b1, pcr_pkg::ADDR_IRQ_CLEAR, 32'hf);
		irq_is(1'b0);
		apb(1'b1, pcr_pkg::ADDR_CONTROL, 32'h1);
		hop <= 1'b1;
		read_card(1'b1);
		rdm(pcr_pkg::ADDR_STATUS, 32'h41, 32'h40);
		rdm(pcr_pkg::ADDR_IRQ_STATUS, 32'h8, 32'h8);
		apb(1'b1, pcr_pkg::ADDR_CONTROL, 32'h1);
		repeat (100) @(posedge pclk);
		check("halt", 32'd160, 32'(strobes));
		press(1'b0);
		rdm(pcr_pkg::ADDR_STATUS, 32'h41, 32'h40);
		hop <= 1'b0;
		press(1'b0);
		rdm(pcr_pkg::ADDR_STATUS, 32'h41, 32'h40);
		press(1'b1);
		press(1'b0);
		rdm(pcr_pkg::ADDR_STATUS, 32'h41, 32'h01);
		results();
	end
endmodule : tb
`default_nettype wire
